// ### logic/cisc_core.sv
// Register file, stack pointer and interrupt sequencing for the CPU core
// How it works
// - Register file gives 8-bit or 16-bit reads and 8-bit or 16-bit write-back.
// - The 32 working registers answer at data addresses 0 to 31.
// - Top six registers form three 16-bit pointers with displacement, increment, decrement.
// - Stack grows down; push lowers pointer one, call or interrupt two.
// - Pop raises pointer one; return or interrupt return raises it two.
// - Stack pointer is two readable writable byte registers cleared at reset.
// - Core runs straight off the selected clock, undivided.
// - One cycle reads two operands, computes, writes the destination.
// - Next instruction is fetched while the current one executes.
// - Interrupt taken only with its own enable and the global enable set.
// - Programmed section lock bits can block interrupts depending on program counter.
// - Vectors lie lowest; lower vector wins, reset first, then request zero.
// - Relocate bit moves vectors to boot start; boot reset fuse moves reset.
// - Entry clears global enable; software may set it; interrupt return sets it.
// - Vectoring clears the flag; writing one also clears it.
// - Flags raised while disabled stay pending, then serve by priority.
// - Level requests count only while their condition is present.
// - After interrupt return one main instruction runs before another interrupt.
// - Status register is neither saved nor restored by hardware.
// - Global disable acts at once, even against a simultaneous request.
// - After the enable instruction the next instruction runs before any pending interrupt.
// - Response takes four clocks pushing the counter, after multi-cycle ops, plus four asleep.
// - Interrupt return takes four clocks: pop counter, pointer up two, set enable.
`include "cisc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module cisc_core (
  input  wire logic                   clock,
  input  wire logic                   reset,
  // Instruction side
  input  wire logic                   instr_retire,
  input  wire logic                   instr_multi_busy,
  input  wire cisc_pkg::cisc_op_t     instr_op,
  input  wire logic [15:0]            pc_now,
  input  wire logic                   sleeping,
  output logic                        fetch_enable,
  output logic                        vector_valid,
  output logic [15:0]                 vector_addr,
  output logic [15:0]                 reset_vector,
  // Register file and pointers
  input  wire cisc_pkg::cisc_rf_req_t rf_req,
  output logic [15:0]                 rf_out_a,
  output logic [7:0]                  rf_out_b,
  input  wire cisc_pkg::cisc_ptr_req_t ptr_req,
  output logic [15:0]                 ptr_addr,
  input  wire cisc_pkg::cisc_mem_t    data_req,
  output logic [7:0]                  data_rdata,
  output logic                        data_hit_regs,
  // Stack pointer I/O registers
  input  wire logic                   io_we,
  input  wire logic [5:0]             io_addr,
  input  wire logic [7:0]             io_wdata,
  output logic [7:0]                  io_rdata,
  output logic [15:0]                 stack_pointer,
  output cisc_pkg::cisc_mem_t         stack_mem,
  // Global enable held in the core flags register bit
  input  wire logic                   core_flags_we,
  input  wire logic [7:0]             core_flags_wdata,
  output logic                        global_enable,
  // Interrupt sources
  input  wire logic [`CISC_NUM_IRQ-1:0] irq_flag_set,
  input  wire logic [`CISC_NUM_IRQ-1:0] irq_flag_wr1c,
  input  wire logic [`CISC_NUM_IRQ-1:0] irq_level,
  input  wire logic [`CISC_NUM_IRQ-1:0] irq_is_level,
  input  wire logic [`CISC_NUM_IRQ-1:0] irq_enable,
  output logic [`CISC_NUM_IRQ-1:0]    irq_flags,
  // Boot controls
  input  wire logic                   vector_table_relocate,
  input  wire logic                   boot_reset_fuse,
  input  wire logic                   app_section_lock_bit,
  input  wire logic                   boot_section_lock_bit,
  input  wire logic [15:0]            boot_start
);
  logic [7:0]                   regs [0:31];
  logic [7:0]                   stack_pointer_low;
  logic [7:0]                   stack_pointer_high;
  cisc_pkg::cisc_state_t        state;
  logic [2:0]                   count;
  logic                         hold_one;
  logic [`CISC_NUM_IRQ-1:0]     pending;
  logic [`CISC_NUM_IRQ-1:0]     req;
  logic [2:0]                   winner;
  logic                         any_req;
  logic                         lock_block;
  logic                         take;
  logic [15:0]                  ret_pc;
  logic [15:0]                  sp;
  logic [15:0]                  next_sp;
  logic [15:0]                  ptr_base;
  logic [15:0]                  ptr_new;
  logic [4:0]                   ptr_lo;

  function automatic logic [4:0] ptr_low_reg(input logic [1:0] sel);
    ptr_low_reg = 5'(5'h18 + {2'h0, sel, 1'h0});
  endfunction

  assign sp = {stack_pointer_high, stack_pointer_low};
  assign stack_pointer = sp;

  // Register file: two read ports, 16-bit port A reads a pair
  assign rf_out_a = {regs[rf_req.rd_a | 5'h01], regs[rf_req.rd_a]};
  assign rf_out_b = regs[rf_req.rd_b];

  // Pointer addressing from the upper register pairs
  assign ptr_lo   = ptr_low_reg(ptr_req.sel);
  assign ptr_base = {regs[ptr_lo | 5'h01], regs[ptr_lo]};
  assign ptr_new  = ptr_req.pre_dec ? ptr_base - 16'h0001 :
                    ptr_req.post_inc ? ptr_base + 16'h0001 : ptr_base;
  assign ptr_addr = ptr_req.pre_dec ? ptr_new : ptr_base + {10'h000, ptr_req.disp};

  assign data_hit_regs = data_req.en && (data_req.addr <= `CISC_REGFILE_TOP);
  assign data_rdata    = data_hit_regs ? regs[data_req.addr[4:0]] : 8'h00;

  // Write priority: data-space store, then result write, then pointer update
  always_ff @(posedge clock) begin
    if (data_hit_regs && data_req.we) begin
      regs[data_req.addr[4:0]] <= data_req.wdata;
    end else if (rf_req.wr_en) begin
      regs[rf_req.wr_addr] <= rf_req.wr_data[7:0];
      if (rf_req.wr_wide) begin
        regs[rf_req.wr_addr | 5'h01] <= rf_req.wr_data[15:8];
      end
    end else if (ptr_req.sel != 2'h0 && (ptr_req.pre_dec || ptr_req.post_inc)) begin
      regs[ptr_lo]         <= ptr_new[7:0];
      regs[ptr_lo | 5'h01] <= ptr_new[15:8];
    end
  end

  // Interrupt request: pending flags or present levels, both enables
  assign req        = ((pending & ~irq_is_level) | (irq_level & irq_is_level)) & irq_enable;
  assign lock_block = (app_section_lock_bit && pc_now < boot_start) ||
                      (boot_section_lock_bit && pc_now >= boot_start);
  assign any_req    = (req != '0) && global_enable && !lock_block;

  always_comb begin
    winner = 3'h0;
    for (int i = `CISC_NUM_IRQ - 1; i >= 0; i--) begin
      if (req[i]) begin
        winner = 3'(i);
      end
    end
  end

  // A disable in this very cycle blocks the take; holdoff covers enable and return
  assign take = (state == cisc_pkg::CISC_RUN) && any_req && !hold_one && !instr_multi_busy &&
                !(instr_retire && instr_op == cisc_pkg::CISC_OP_CLI) &&
                !(core_flags_we && !core_flags_wdata[`CISC_GIE_BIT]);

  // Flags: set beats hardware or software clear
  always_ff @(posedge clock) begin
    if (reset) begin
      pending <= '0;
    end else begin
      for (int i = 0; i < `CISC_NUM_IRQ; i++) begin
        if (irq_flag_set[i]) begin
          pending[i] <= 1'b1;
        end else if (irq_flag_wr1c[i] || (take && winner == 3'(i))) begin
          pending[i] <= 1'b0;
        end
      end
    end
  end
  assign irq_flags = pending;

  // Sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= cisc_pkg::CISC_RUN;
      count <= 3'h0;
    end else begin
      case (state)
        cisc_pkg::CISC_RUN: begin
          if (take) begin
            state <= sleeping ? cisc_pkg::CISC_WAKE : cisc_pkg::CISC_ENTRY;
            count <= sleeping ? `CISC_SLEEP_EXTRA - 3'h1 : `CISC_ENTRY_CYCLES - 3'h1;
          end else if (instr_retire && instr_op == cisc_pkg::CISC_OP_RETURN_FROM_INTERRUPT_OP) begin
            state <= cisc_pkg::CISC_RETURN_FROM_INTERRUPT_OP;
            count <= `CISC_RETURN_FROM_INTERRUPT_OP_CYCLES - 3'h1;
          end
        end
        cisc_pkg::CISC_WAKE: begin
          if (count == 3'h0) begin
            state <= cisc_pkg::CISC_ENTRY;
            count <= `CISC_ENTRY_CYCLES - 3'h1;
          end else begin
            count <= count - 3'h1;
          end
        end
        cisc_pkg::CISC_ENTRY, cisc_pkg::CISC_RETURN_FROM_INTERRUPT_OP: begin
          if (count == 3'h0) begin
            state <= cisc_pkg::CISC_RUN;
          end else begin
            count <= count - 3'h1;
          end
        end
        default: state <= cisc_pkg::CISC_RUN;
      endcase
    end
  end

  // One instruction must retire after enable or return before a take
  always_ff @(posedge clock) begin
    if (reset) begin
      hold_one <= 1'b0;
    end else if ((instr_retire && instr_op == cisc_pkg::CISC_OP_SEI) ||
                 (state == cisc_pkg::CISC_RETURN_FROM_INTERRUPT_OP && count == 3'h0)) begin
      hold_one <= 1'b1;
    end else if (instr_retire && state == cisc_pkg::CISC_RUN) begin
      hold_one <= 1'b0;
    end
  end

  // Global enable; status bits otherwise untouched by entry and return
  always_ff @(posedge clock) begin
    if (reset) begin
      global_enable <= 1'b0;
    end else if (take) begin
      global_enable <= 1'b0;
    end else if (state == cisc_pkg::CISC_RETURN_FROM_INTERRUPT_OP && count == 3'h0) begin
      global_enable <= 1'b1;
    end else if (instr_retire && instr_op == cisc_pkg::CISC_OP_CLI) begin
      global_enable <= 1'b0;
    end else if (instr_retire && instr_op == cisc_pkg::CISC_OP_SEI) begin
      global_enable <= 1'b1;
    end else if (core_flags_we) begin
      global_enable <= core_flags_wdata[`CISC_GIE_BIT];
    end
  end

  // Vector and return address capture
  always_ff @(posedge clock) begin
    if (reset) begin
      vector_addr <= 16'h0000;
      ret_pc      <= 16'h0000;
    end else if (take) begin
      vector_addr <= (vector_table_relocate ? boot_start : 16'h0000) +
                     16'(({13'h0000, winner} + 16'h0001) * `CISC_IRQ_VEC_STEP);
      ret_pc      <= pc_now;
    end
  end
  assign reset_vector = boot_reset_fuse ? boot_start : 16'h0000;
  assign vector_valid = (state == cisc_pkg::CISC_ENTRY) && (count == 3'h0);
  assign fetch_enable = (state == cisc_pkg::CISC_RUN);

  // Stack pointer arithmetic
  always_comb begin
    next_sp = sp;
    if (state == cisc_pkg::CISC_ENTRY && count == `CISC_ENTRY_CYCLES - 3'h1) begin
      next_sp = sp - 16'h0002;
    end else if (state == cisc_pkg::CISC_RETURN_FROM_INTERRUPT_OP && count == `CISC_RETURN_FROM_INTERRUPT_OP_CYCLES - 3'h1) begin
      next_sp = sp + 16'h0002;
    end else if (instr_retire && state == cisc_pkg::CISC_RUN) begin
      case (instr_op)
        cisc_pkg::CISC_OP_PUSH: next_sp = sp - 16'h0001;
        cisc_pkg::CISC_OP_CALL: next_sp = sp - 16'h0002;
        cisc_pkg::CISC_OP_POP:  next_sp = sp + 16'h0001;
        cisc_pkg::CISC_OP_RET:  next_sp = sp + 16'h0002;
        default:                next_sp = sp;
      endcase
    end
  end

  // Software write wins over stack motion in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      stack_pointer_low  <= 8'(`CISC_SP_RESET);
      stack_pointer_high <= 8'(`CISC_SP_RESET >> 8);
    end else begin
      stack_pointer_low  <= (io_we && io_addr == `CISC_SPL_ADDR) ? io_wdata : next_sp[7:0];
      stack_pointer_high <= (io_we && io_addr == `CISC_SPH_ADDR) ? io_wdata : next_sp[15:8];
    end
  end

  always_comb begin
    if (io_addr == `CISC_SPL_ADDR) begin
      io_rdata = stack_pointer_low;
    end else if (io_addr == `CISC_SPH_ADDR) begin
      io_rdata = stack_pointer_high;
    end else begin
      io_rdata = 8'h00;
    end
  end

  // Return address writes during entry: low byte at sp, high at sp-1
  always_comb begin
    stack_mem = '0;
    if (state == cisc_pkg::CISC_ENTRY && count == `CISC_ENTRY_CYCLES - 3'h1) begin
      stack_mem = '{en: 1'b1, we: 1'b1, addr: sp, wdata: ret_pc[7:0]};
    end else if (state == cisc_pkg::CISC_ENTRY && count == `CISC_ENTRY_CYCLES - 3'h2) begin
      stack_mem = '{en: 1'b1, we: 1'b1, addr: sp + 16'h0001, wdata: ret_pc[15:8]};
    end else if (state == cisc_pkg::CISC_RETURN_FROM_INTERRUPT_OP && count == `CISC_RETURN_FROM_INTERRUPT_OP_CYCLES - 3'h1) begin
      stack_mem = '{en: 1'b1, we: 1'b0, addr: sp + 16'h0001, wdata: 8'h00};
    end else if (state == cisc_pkg::CISC_RETURN_FROM_INTERRUPT_OP && count == `CISC_RETURN_FROM_INTERRUPT_OP_CYCLES - 3'h2) begin
      stack_mem = '{en: 1'b1, we: 1'b0, addr: sp, wdata: 8'h00};
    end
  end

  a_entry_clears_gie: assert property (@(posedge clock) disable iff (reset)
    take |=> !global_enable) else $error("global enable not cleared on entry");
  a_entry_sp_down: assert property (@(posedge clock) disable iff (reset)
    take && !sleeping && !io_we |=> ##1 stack_pointer == $past(stack_pointer, 2) - 16'h0002)
    else $error("stack pointer not lowered by two on entry");
  a_entry_four: assert property (@(posedge clock) disable iff (reset)
    take && !sleeping |-> ##4 vector_valid ##1 !vector_valid)
    else $error("entry not four cycles");
  a_sleep_eight: assert property (@(posedge clock) disable iff (reset)
    take && sleeping |-> ##8 vector_valid ##1 !vector_valid)
    else $error("entry from sleep not eight cycles");
  a_return_from_interrupt_op_sets_gie: assert property (@(posedge clock) disable iff (reset)
    state == cisc_pkg::CISC_RUN && instr_retire && instr_op == cisc_pkg::CISC_OP_RETURN_FROM_INTERRUPT_OP && !take
    |-> ##5 global_enable) else $error("interrupt return did not set enable");
  a_return_from_interrupt_op_sp_up: assert property (@(posedge clock) disable iff (reset)
    state == cisc_pkg::CISC_RUN && instr_retire && instr_op == cisc_pkg::CISC_OP_RETURN_FROM_INTERRUPT_OP && !take
    && !io_we |=> ##1 stack_pointer == $past(stack_pointer, 2) + 16'h0002)
    else $error("interrupt return did not raise pointer by two");
  a_cli_blocks: assert property (@(posedge clock) disable iff (reset)
    instr_retire && instr_op == cisc_pkg::CISC_OP_CLI |-> !take)
    else $error("take in disable cycle");
  a_take_enabled: assert property (@(posedge clock) disable iff (reset)
    take |-> global_enable && irq_enable[winner]) else $error("take while disabled");
  a_take_clears_flag: assert property (@(posedge clock) disable iff (reset)
    take && !irq_flag_set[winner] |=> !pending[$past(winner)])
    else $error("flag not cleared on vectoring");
  a_sei_holdoff: assert property (@(posedge clock) disable iff (reset)
    instr_retire && instr_op == cisc_pkg::CISC_OP_SEI |=> !take)
    else $error("take right after enable");
  a_set_wins: assert property (@(posedge clock) disable iff (reset)
    irq_flag_set != '0 |=> (pending & $past(irq_flag_set)) == $past(irq_flag_set))
    else $error("flag set lost");
  a_push_down: assert property (@(posedge clock) disable iff (reset)
    state == cisc_pkg::CISC_RUN && !take && instr_retire && instr_op == cisc_pkg::CISC_OP_PUSH
    && !io_we |=> stack_pointer == $past(stack_pointer) - 16'h0001)
    else $error("push did not lower pointer");
  a_pop_up: assert property (@(posedge clock) disable iff (reset)
    state == cisc_pkg::CISC_RUN && !take && instr_retire && instr_op == cisc_pkg::CISC_OP_POP
    && !io_we |=> stack_pointer == $past(stack_pointer) + 16'h0001)
    else $error("pop did not raise pointer");
endmodule // cisc_core
`default_nettype wire

// ### logic/cisc_params.svh
// Constants for the core interrupt and stack control block
`ifndef CISC_PARAMS_SVH
`define CISC_PARAMS_SVH
`define CISC_SPL_ADDR      6'h3D
`define CISC_SPH_ADDR      6'h3E
`define CISC_SP_RESET      16'h0000
`define CISC_REGFILE_TOP   16'h001F
`define CISC_NUM_IRQ       8
`define CISC_ENTRY_CYCLES  3'h4
`define CISC_SLEEP_EXTRA   3'h4
`define CISC_RETURN_FROM_INTERRUPT_OP_CYCLES   3'h4
`define CISC_IRQ_VEC_STEP  16'h0002
`define CISC_GIE_BIT       7
`endif

// ### logic/cisc_pkg.sv
// Types for the core interrupt and stack control block
`default_nettype none
package cisc_pkg;
  typedef enum logic [2:0] {
    CISC_RUN   = 3'h0,
    CISC_WAKE  = 3'h1,
    CISC_ENTRY = 3'h2,
    CISC_RETURN_FROM_INTERRUPT_OP  = 3'h3,
    CISC_HOLD  = 3'h4
  } cisc_state_t;
  typedef enum logic [2:0] {
    CISC_OP_NONE = 3'h0,
    CISC_OP_PUSH = 3'h1,
    CISC_OP_POP  = 3'h2,
    CISC_OP_CALL = 3'h3,
    CISC_OP_RET  = 3'h4,
    CISC_OP_RETURN_FROM_INTERRUPT_OP = 3'h5,
    CISC_OP_SEI  = 3'h6,
    CISC_OP_CLI  = 3'h7
  } cisc_op_t;
  // Register file access: two reads, one write of 8 or 16 bits
  typedef struct packed {
    logic [4:0]  rd_a;
    logic [4:0]  rd_b;
    logic [4:0]  wr_addr;
    logic        wr_en;
    logic        wr_wide;
    logic [15:0] wr_data;
  } cisc_rf_req_t;
  // Pointer update: select 1..3, mode, displacement
  typedef struct packed {
    logic [1:0]  sel;
    logic        post_inc;
    logic        pre_dec;
    logic [5:0]  disp;
  } cisc_ptr_req_t;
  // Data-space access toward registers or stack SRAM
  typedef struct packed {
    logic        en;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cisc_mem_t;
endpackage
`default_nettype wire

// ### tb/cisc_stack_sram.sv
// Stack SRAM model on the far side of the core
`timescale 1ns/1ps
`default_nettype none
module cisc_stack_sram (
  input  wire logic                clock,
  input  wire cisc_pkg::cisc_mem_t stack_mem,
  input  wire logic [15:0]         peek_addr,
  output logic [7:0]               peek_data
);
  logic [7:0] mem [0:4095];
  // Writes only, since the core has no read-data path from this memory
  always @(posedge clock) begin
    if (stack_mem.en && stack_mem.we) begin
      mem[stack_mem.addr[11:0]] <= stack_mem.wdata;
    end
  end
  // Cells never written stay unknown, so a missing push cannot match
  assign peek_data = mem[peek_addr[11:0]];
endmodule // cisc_stack_sram
`default_nettype wire

// ### tb/cisc_core_bench.sv
// Self-checking bench for the core interrupt and stack control block
`include "cisc_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module cisc_core_bench;
  logic        clock, reset, instr_retire, instr_multi_busy, sleeping, io_we, core_flags_we;
  logic        vector_table_relocate, boot_reset_fuse, app_section_lock_bit, boot_section_lock_bit;
  logic        fetch_enable, vector_valid, data_hit_regs, global_enable;
  logic [15:0] pc_now, boot_start, vector_addr, reset_vector, rf_out_a, ptr_addr, stack_pointer;
  logic [15:0] exp_sp, peek_addr;
  logic [7:0]  rf_out_b, data_rdata, io_rdata, io_wdata, core_flags_wdata, peek_data;
  logic [7:0]  irq_flag_set, irq_flag_wr1c, irq_level, irq_is_level, irq_enable, irq_flags;
  logic [5:0]  io_addr;
  int          mismatches, total_checks, cycles;
  logic [15:0] step [1:4] = '{16'hFFFF, 16'h0001, 16'hFFFE, 16'h0002};
  cisc_pkg::cisc_op_t      instr_op;
  cisc_pkg::cisc_rf_req_t  rf_req;
  cisc_pkg::cisc_ptr_req_t ptr_req;
  cisc_pkg::cisc_mem_t     data_req, stack_mem;

  cisc_core DUT (.clock(clock), .reset(reset), .instr_retire(instr_retire),
    .instr_multi_busy(instr_multi_busy), .instr_op(instr_op), .pc_now(pc_now),
    .sleeping(sleeping), .fetch_enable(fetch_enable), .vector_valid(vector_valid),
    .vector_addr(vector_addr), .reset_vector(reset_vector), .rf_req(rf_req),
    .rf_out_a(rf_out_a), .rf_out_b(rf_out_b), .ptr_req(ptr_req), .ptr_addr(ptr_addr),
    .data_req(data_req), .data_rdata(data_rdata), .data_hit_regs(data_hit_regs),
    .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .stack_pointer(stack_pointer), .stack_mem(stack_mem), .core_flags_we(core_flags_we),
    .core_flags_wdata(core_flags_wdata), .global_enable(global_enable),
    .irq_flag_set(irq_flag_set), .irq_flag_wr1c(irq_flag_wr1c), .irq_level(irq_level),
    .irq_is_level(irq_is_level), .irq_enable(irq_enable), .irq_flags(irq_flags),
    .vector_table_relocate(vector_table_relocate), .boot_reset_fuse(boot_reset_fuse),
    .app_section_lock_bit(app_section_lock_bit),
    .boot_section_lock_bit(boot_section_lock_bit), .boot_start(boot_start));

  cisc_stack_sram SRAM (.clock(clock), .stack_mem(stack_mem), .peek_addr(peek_addr),
    .peek_data(peek_data));

  always #2.5 clock = ~clock;

  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard, far above the hundred-odd cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic retire(cisc_pkg::cisc_op_t op);
    @(posedge clock);
    instr_retire <= 1'b1;
    instr_op     <= op;
    @(posedge clock);
    instr_retire <= 1'b0;
    instr_op     <= cisc_pkg::CISC_OP_NONE;
    #1;
  endtask

  task automatic io_wr(logic [5:0] a, logic [7:0] d);
    @(posedge clock);
    io_we   <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clock);
    io_we <= 1'b0;
  endtask

  task automatic io_rd(logic [5:0] a, logic [7:0] d);
    @(posedge clock);
    io_addr <= a;
    #1;
    `CHK(io_rdata, d)
  endtask

  task automatic flags_wr(logic [7:0] d);
    @(posedge clock);
    core_flags_we    <= 1'b1;
    core_flags_wdata <= d;
    @(posedge clock);
    core_flags_we <= 1'b0;
    #1;
  endtask

  task automatic rf_wr(logic [4:0] a, logic w, logic [15:0] d);
    @(posedge clock);
    rf_req <= '{wr_addr: a, wr_en: 1'b1, wr_wide: w, wr_data: d, default: '0};
    @(posedge clock);
    rf_req.wr_en <= 1'b0;
  endtask

  // Run state must hold: nothing is taken
  task automatic idle(int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      `CHK(fetch_enable, 1'b1)
    end
  endtask

  // Gap counts cycles from leaving run state to the vector cycle
  task automatic entry(logic [15:0] vec, logic [15:0] ret, int gap);
    int n;
    n = 0;
    while (fetch_enable === 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    `CHK(stack_pointer, exp_sp)
    exp_sp = exp_sp - 16'h0002;
    // Pointer drops on the first push cycle, two cycles before the vector
    repeat (gap - 2) @(posedge clock);
    #1;
    `CHK(stack_pointer, exp_sp)
    repeat (2) @(posedge clock);
    #1;
    `CHK(vector_valid, 1'b1)
    `CHK(vector_addr, vec)
    `CHK(global_enable, 1'b0)
    // Low byte at the old pointer, high byte just below it
    peek_addr = exp_sp + 16'h0002;
    #1;
    `CHK(peek_data, ret[7:0])
    peek_addr = exp_sp + 16'h0001;
    #1;
    `CHK(peek_data, ret[15:8])
    @(posedge clock);
    #1;
    `CHK(vector_valid, 1'b0)
  endtask

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    {instr_retire, instr_multi_busy, sleeping, io_we, core_flags_we} = '0;
    {vector_table_relocate, boot_reset_fuse, app_section_lock_bit, boot_section_lock_bit} = '0;
    {irq_flag_set, irq_flag_wr1c, irq_level, irq_is_level, irq_enable} = '0;
    {io_addr, io_wdata, core_flags_wdata, mismatches, total_checks, cycles} = '0;
    {rf_req, ptr_req, data_req, peek_addr} = '0;
    instr_op = cisc_pkg::CISC_OP_NONE;
    pc_now = 16'h0123;
    boot_start = 16'h4000;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1;
    `CHK(stack_pointer, `CISC_SP_RESET)
    `CHK(irq_flags, 8'h00)
    `CHK(reset_vector, 16'h0000)
    io_rd(`CISC_SPL_ADDR, 8'h00);
    io_rd(`CISC_SPH_ADDR, 8'h00);
    io_rd(6'h10, 8'h00);
    io_wr(`CISC_SPH_ADDR, 8'h01);
    io_wr(`CISC_SPL_ADDR, 8'h00);
    io_rd(`CISC_SPH_ADDR, 8'h01);
    exp_sp = 16'h0100;
    for (int i = 1; i <= 4; i++) begin
      retire(cisc_pkg::cisc_op_t'(i));
      exp_sp = exp_sp + step[i];
      `CHK(stack_pointer, exp_sp)
    end
    rf_wr(5'h05, 1'b0, 16'h00A5);
    rf_wr(5'h1A, 1'b1, 16'h1234);
    rf_wr(5'h1C, 1'b1, 16'h0200);
    @(posedge clock);
    rf_req <= '{rd_a: 5'h1A, rd_b: 5'h05, default: '0};
    data_req <= '{en: 1'b1, we: 1'b0, addr: 16'h001B, wdata: 8'h00};
    ptr_req <= '{sel: 2'h1, default: '0};
    #1;
    `CHK(rf_out_a, 16'h1234)
    `CHK(rf_out_b, 8'hA5)
    `CHK(data_rdata, 8'h12)
    `CHK(data_hit_regs, 1'b1)
    `CHK(ptr_addr, 16'h1234)
    @(posedge clock);
    data_req <= '{en: 1'b1, we: 1'b1, addr: 16'h0007, wdata: 8'h5A};
    ptr_req <= '{sel: 2'h2, disp: 6'h03, default: '0};
    rf_req.rd_b <= 5'h07;
    #1;
    `CHK(ptr_addr, 16'h0203)
    @(posedge clock);
    data_req <= '{en: 1'b0, we: 1'b0, addr: 16'h0020, wdata: 8'h00};
    ptr_req <= '{sel: 2'h1, pre_dec: 1'b1, default: '0};
    #1;
    `CHK(rf_out_b, 8'h5A)
    `CHK(data_hit_regs, 1'b0)
    `CHK(ptr_addr, 16'h1233)
    @(posedge clock);
    ptr_req <= '{sel: 2'h1, post_inc: 1'b1, default: '0};
    #1;
    `CHK(ptr_addr, 16'h1233)
    @(posedge clock);
    ptr_req <= '0;
    irq_enable <= 8'h0A;
    irq_flag_set <= 8'h0A;
    @(posedge clock);
    irq_flag_set <= 8'h00;
    idle(3);
    `CHK(irq_flags, 8'h0A)
    `CHK(rf_out_a, 16'h1234)
    retire(cisc_pkg::CISC_OP_SEI);
    `CHK(global_enable, 1'b1)
    idle(3);
    retire(cisc_pkg::CISC_OP_NONE);
    entry(16'h0004, 16'h0123, 3);
    `CHK(irq_flags, 8'h08)
    retire(cisc_pkg::CISC_OP_RETURN_FROM_INTERRUPT_OP);
    exp_sp = exp_sp + 16'h0002;
    `CHK(fetch_enable, 1'b0)
    @(posedge clock);
    #1;
    `CHK(stack_pointer, exp_sp)
    `CHK(global_enable, 1'b0)
    repeat (3) @(posedge clock);
    #1;
    `CHK(global_enable, 1'b1)
    idle(3);
    retire(cisc_pkg::CISC_OP_NONE);
    entry(16'h0008, 16'h0123, 3);
    @(posedge clock);
    irq_enable <= 8'h00;
    irq_flag_set <= 8'h20;
    irq_flag_wr1c <= 8'h20;
    @(posedge clock);
    irq_flag_set <= 8'h00;
    irq_flag_wr1c <= 8'h20;
    #1;
    `CHK(irq_flags, 8'h20)
    @(posedge clock);
    irq_flag_wr1c <= 8'h00;
    irq_enable <= 8'h04;
    #1;
    `CHK(irq_flags, 8'h00)
    flags_wr(8'h80);
    `CHK(global_enable, 1'b1)
    // Flag pending and enabled as the disable retires: only the disable stops it
    @(posedge clock);
    irq_flag_set <= 8'h04;
    @(posedge clock);
    instr_retire <= 1'b1;
    instr_op <= cisc_pkg::CISC_OP_CLI;
    irq_flag_set <= 8'h00;
    @(posedge clock);
    instr_retire <= 1'b0;
    instr_op <= cisc_pkg::CISC_OP_NONE;
    idle(4);
    `CHK(global_enable, 1'b0)
    `CHK(irq_flags, 8'h04)
    @(posedge clock);
    irq_flag_wr1c <= 8'h04;
    {irq_enable, irq_is_level, irq_level} <= {8'h40, 8'h40, 8'h40};
    @(posedge clock);
    irq_flag_wr1c <= 8'h00;
    irq_level <= 8'h00;
    retire(cisc_pkg::CISC_OP_SEI);
    retire(cisc_pkg::CISC_OP_NONE);
    idle(4);
    @(posedge clock);
    {vector_table_relocate, boot_reset_fuse, irq_level} <= {1'b1, 1'b1, 8'h40};
    entry(boot_start + 16'h000E, 16'h0123, 3);
    `CHK(reset_vector, boot_start)
    @(posedge clock);
    app_section_lock_bit <= 1'b1;
    flags_wr(8'h80);
    idle(4);
    @(posedge clock);
    {instr_multi_busy, sleeping, pc_now} <= {1'b1, 1'b1, 16'h4100};
    idle(3);
    @(posedge clock);
    instr_multi_busy <= 1'b0;
    entry(boot_start + 16'h000E, 16'h4100, 7);
    stop_test();
  end
endmodule // cisc_core_bench
`default_nettype wire
